//--- hdl/apfs_regs.svh
`ifndef APFS_REGS_SVH
`define APFS_REGS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define APFS_SEL_OFS      32'h0000_0000
`define APFS_STAT_OFS     32'h0000_0004

// Select register field positions.
`define APFS_RX_BIT       7
`define APFS_SDO_BIT      6
`define APFS_SS_BIT       5
`define APFS_UNIMP_BIT    4
`define APFS_TG_BIT       3
`define APFS_TX_BIT       2

// Reset value and writable bits for each package variant.
`define APFS_SEL_RESET    8'h00
`define APFS_SEL_MASK14   8'hEC
`define APFS_SEL_MASK20   8'h8C

// Status register layout: five 4-bit pin codes, then the variant flag.
`define APFS_STAT_VAR_BIT 20

// AXI response codes.
`define APFS_RESP_OKAY    2'b00
`define APFS_RESP_DECERR  2'b11

// Counts of routed functions and of candidate pins.
`define APFS_NFN          5
`define APFS_NPIN         12

`endif

//--- hdl/apfs_pkg.sv
package apfs_pkg;

    typedef enum logic [3:0] {
        APFS_RA0,
        APFS_RA1,
        APFS_RA3,
        APFS_RA4,
        APFS_RB5,
        APFS_RB7,
        APFS_RC2,
        APFS_RC3,
        APFS_RC4,
        APFS_RC5,
        APFS_RC6,
        APFS_RC7
    } apfs_pin_t;

    typedef enum logic [2:0] {
        APFS_FN_RX,
        APFS_FN_SDO,
        APFS_FN_SS,
        APFS_FN_TG,
        APFS_FN_TX
    } apfs_fn_t;

endpackage

//--- hdl/apfs_fn_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "apfs_regs.svh"

interface apfs_fn_if;
    import apfs_pkg::*;

    apfs_pin_t            pin [`APFS_NFN];
    logic [`APFS_NFN-1:0] out;
    logic [`APFS_NFN-1:0] oe;
    logic [`APFS_NFN-1:0] in;

    modport src (output pin, output out, output oe, input in);
    modport mux (input pin, input out, input oe, output in);
endinterface

`default_nettype wire

//--- hdl/apfs_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "apfs_regs.svh"

module apfs_pin_mux
    import apfs_pkg::*;
(
    apfs_fn_if.mux                       fn,
    input  wire logic [`APFS_NPIN-1:0]   pin_in,
    input  wire logic [`APFS_NPIN-1:0]   gpio_out,
    input  wire logic [`APFS_NPIN-1:0]   gpio_oe,
    output logic      [`APFS_NPIN-1:0]   pad_out_nxt,
    output logic      [`APFS_NPIN-1:0]   pad_oe_nxt
);

    // A pin keeps its port behaviour unless the function routed to it is
    // driving; the lowest function number wins if two ever meet on one pin.
    always_comb
    begin
        pad_out_nxt = gpio_out;
        pad_oe_nxt  = gpio_oe;
        for (int p = 0; p < `APFS_NPIN; p++)
        begin
            for (int f = `APFS_NFN - 1; f >= 0; f--)
            begin
                if (fn.oe[f] && (fn.pin[f] == apfs_pin_t'(4'(p))))
                begin
                    pad_out_nxt[p] = fn.out[f];
                    pad_oe_nxt[p]  = 1'b1;
                end
            end
        end
    end

    // Each function samples only the pin it is routed to.
    always_comb
    begin
        for (int f = 0; f < `APFS_NFN; f++)
        begin
            fn.in[f] = pin_in[fn.pin[f]];
        end
    end

endmodule

`default_nettype wire

//--- hdl/apfs_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "apfs_regs.svh"

module apfs_top
    import apfs_pkg::*;
#(
    parameter bit PIN20  = 1'b1,
    parameter int ADDR_W = 4
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [`APFS_NPIN-1:0] pad_in,
    output logic      [`APFS_NPIN-1:0] pad_out,
    output logic      [`APFS_NPIN-1:0] pad_oe,
    input  wire logic [`APFS_NPIN-1:0] gpio_out,
    input  wire logic [`APFS_NPIN-1:0] gpio_oe,
    output logic      [`APFS_NPIN-1:0] gpio_in,
    input  wire logic                  serial_receive_data_out,
    input  wire logic                  serial_receive_data_oe,
    output logic                       serial_receive_data_in,
    input  wire logic                  serial_transmit_clock_out,
    input  wire logic                  serial_transmit_clock_oe,
    output logic                       serial_transmit_clock_in,
    input  wire logic                  spi_serial_dout,
    input  wire logic                  spi_serial_dout_oe,
    output logic                       spi_slave_select_in_n,
    output logic                       timer_gate_input
);

    localparam logic [7:0] SEL_MASK = PIN20 ? `APFS_SEL_MASK20 : `APFS_SEL_MASK14;

    logic [7:0]            sel_r;
    logic                  aw_got_r;
    logic [ADDR_W-1:0]     awaddr_r;
    logic                  w_got_r;
    logic [7:0]            wdata_r;
    logic                  wstrb0_r;
    logic                  bvalid_r;
    logic [1:0]            bresp_r;
    logic                  rvalid_r;
    logic [31:0]           rdata_r;
    logic [1:0]            rresp_r;
    logic [`APFS_NPIN-1:0] pin_meta_r;
    logic [`APFS_NPIN-1:0] pin_sync_r;
    logic [`APFS_NPIN-1:0] pad_out_nxt;
    logic [`APFS_NPIN-1:0] pad_oe_nxt;
    logic [`APFS_NPIN-1:0] pad_out_r;
    logic [`APFS_NPIN-1:0] pad_oe_r;
    logic                  rx_in_r;
    logic                  tx_in_r;
    logic                  ss_in_r;
    logic                  tg_in_r;
    logic                  do_write;
    logic                  aw_is_sel;
    logic                  aw_is_stat;
    logic                  ar_is_sel;
    logic                  ar_is_stat;
    logic [31:0]           status;

    apfs_fn_if fn_bus ();

    // Bus slave.

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign do_write   = aw_got_r && w_got_r;
    assign aw_is_sel  = {awaddr_r[ADDR_W-1:2], 2'b00} == ADDR_W'(`APFS_SEL_OFS);
    assign aw_is_stat = {awaddr_r[ADDR_W-1:2], 2'b00} == ADDR_W'(`APFS_STAT_OFS);
    assign ar_is_sel  = {s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(`APFS_SEL_OFS);
    assign ar_is_stat = {s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(`APFS_STAT_OFS);

    // Address and data are latched separately so either may come first.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            aw_got_r <= 1'b0;
            awaddr_r <= '0;
            w_got_r  <= 1'b0;
            wdata_r  <= 8'h00;
            wstrb0_r <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_got_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r  <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            else if (do_write)
            begin
                w_got_r <= 1'b0;
            end
        end
    end

    // Bits outside the variant's mask, bit 4 among them, never store.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sel_r <= `APFS_SEL_RESET;
        end
        else if (do_write && aw_is_sel && wstrb0_r)
        begin
            sel_r <= wdata_r & SEL_MASK;
        end
    end

    // Writes to the status word are accepted and dropped.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= `APFS_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= (aw_is_sel || aw_is_stat) ? `APFS_RESP_OKAY : `APFS_RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    assign status = {11'h000, PIN20,
                     fn_bus.pin[APFS_FN_TX], fn_bus.pin[APFS_FN_TG],
                     fn_bus.pin[APFS_FN_SS], fn_bus.pin[APFS_FN_SDO],
                     fn_bus.pin[APFS_FN_RX]};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `APFS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= (ar_is_sel || ar_is_stat) ? `APFS_RESP_OKAY : `APFS_RESP_DECERR;
            if (ar_is_sel)
            begin
                rdata_r <= {24'h000000, sel_r & SEL_MASK};
            end
            else if (ar_is_stat)
            begin
                rdata_r <= status;
            end
            else
            begin
                rdata_r <= 32'h0000_0000;
            end
        end
        else if (s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // Routing of each function to its pin.

    always_comb
    begin
        fn_bus.pin[APFS_FN_RX]  = PIN20 ? (sel_r[`APFS_RX_BIT] ? APFS_RC5 : APFS_RB5)
                                        : (sel_r[`APFS_RX_BIT] ? APFS_RA1 : APFS_RC5);
        fn_bus.pin[APFS_FN_SDO] = PIN20 ? APFS_RC7
                                        : (sel_r[`APFS_SDO_BIT] ? APFS_RA4 : APFS_RC2);
        fn_bus.pin[APFS_FN_SS]  = PIN20 ? APFS_RC6
                                        : (sel_r[`APFS_SS_BIT] ? APFS_RA3 : APFS_RC3);
        fn_bus.pin[APFS_FN_TG]  = sel_r[`APFS_TG_BIT] ? APFS_RA3 : APFS_RA4;
        fn_bus.pin[APFS_FN_TX]  = PIN20 ? (sel_r[`APFS_TX_BIT] ? APFS_RC4 : APFS_RB7)
                                        : (sel_r[`APFS_TX_BIT] ? APFS_RA0 : APFS_RC4);
        fn_bus.out = {serial_transmit_clock_out, 1'b0, 1'b0,
                      spi_serial_dout, serial_receive_data_out};
        fn_bus.oe  = {serial_transmit_clock_oe, 1'b0, 1'b0,
                      spi_serial_dout_oe, serial_receive_data_oe};
    end

    apfs_pin_mux u_mux (
        .fn          (fn_bus.mux),
        .pin_in      (pin_sync_r),
        .gpio_out    (gpio_out),
        .gpio_oe     (gpio_oe),
        .pad_out_nxt (pad_out_nxt),
        .pad_oe_nxt  (pad_oe_nxt)
    );

    // Pad levels come from outside the clock domain and are synchronised first.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else
        begin
            pin_meta_r <= pad_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Registered pad drive keeps glitches from select changes off the pins.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pad_out_r <= '0;
            pad_oe_r  <= '0;
        end
        else
        begin
            pad_out_r <= pad_out_nxt;
            pad_oe_r  <= pad_oe_nxt;
        end
    end

    // Slave select resets high so the SPI is deselected in reset, then reads low for two cycles from the synchroniser's reset value.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_in_r <= 1'b0;
            tx_in_r <= 1'b0;
            ss_in_r <= 1'b1;
            tg_in_r <= 1'b0;
        end
        else
        begin
            rx_in_r <= fn_bus.in[APFS_FN_RX];
            tx_in_r <= fn_bus.in[APFS_FN_TX];
            ss_in_r <= fn_bus.in[APFS_FN_SS];
            tg_in_r <= fn_bus.in[APFS_FN_TG];
        end
    end

    assign pad_out                  = pad_out_r;
    assign pad_oe                   = pad_oe_r;
    assign gpio_in                  = pin_sync_r;
    assign serial_receive_data_in   = rx_in_r;
    assign serial_transmit_clock_in = tx_in_r;
    assign spi_slave_select_in_n    = ss_in_r;
    assign timer_gate_input         = tg_in_r;

    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    rx20_route_a: assert property (
        PIN20 && sel_r[`APFS_RX_BIT] && serial_receive_data_oe
        |=> pad_oe[APFS_RC5] && pad_out[APFS_RC5] == $past(serial_receive_data_out))
        else $error("receive data not driven on RC5");

    rx14_route_a: assert property (
        !PIN20 && sel_r[`APFS_RX_BIT] && serial_receive_data_oe
        |=> pad_oe[APFS_RA1] && pad_out[APFS_RA1] == $past(serial_receive_data_out))
        else $error("receive data not driven on RA1");

    sdo14_route_a: assert property (
        !PIN20 && !sel_r[`APFS_SDO_BIT] && spi_serial_dout_oe
        |=> pad_oe[APFS_RC2] && pad_out[APFS_RC2] == $past(spi_serial_dout))
        else $error("SPI data out not on RC2");

    sdo20_fixed_a: assert property (
        PIN20 && spi_serial_dout_oe
        |=> pad_oe[APFS_RC7] && pad_out[APFS_RC7] == $past(spi_serial_dout))
        else $error("SPI data out not on RC7");

    ss14_route_a: assert property (
        !PIN20 && sel_r[`APFS_SS_BIT]
        |=> spi_slave_select_in_n == $past(pin_sync_r[APFS_RA3]))
        else $error("slave select not taken from RA3");

    ss20_fixed_a: assert property (
        PIN20 |=> spi_slave_select_in_n == $past(pin_sync_r[APFS_RC6]))
        else $error("slave select not taken from RC6");

    ro20_read_a: assert property (
        PIN20 && s_axi_arvalid && s_axi_arready && ar_is_sel
        |=> s_axi_rvalid && s_axi_rdata[6:5] == 2'b00)
        else $error("read-only select bits read nonzero");

    bit4_read_a: assert property (
        s_axi_arvalid && s_axi_arready && ar_is_sel
        |=> s_axi_rvalid && !s_axi_rdata[`APFS_UNIMP_BIT])
        else $error("unimplemented bit reads one");

    gate_route_a: assert property (
        !sel_r[`APFS_TG_BIT] |=> timer_gate_input == $past(pin_sync_r[APFS_RA4]))
        else $error("timer gate not taken from RA4");

    tx14_route_a: assert property (
        !PIN20 && sel_r[`APFS_TX_BIT] && serial_transmit_clock_oe
        |=> pad_oe[APFS_RA0] && pad_out[APFS_RA0] == $past(serial_transmit_clock_out))
        else $error("transmit clock not on RA0");

    tx20_route_a: assert property (
        PIN20 && !sel_r[`APFS_TX_BIT] && serial_transmit_clock_oe
        |=> pad_oe[APFS_RB7] && pad_out[APFS_RB7] == $past(serial_transmit_clock_out))
        else $error("transmit clock not on RB7");

    unsel_port_a: assert property (
        PIN20 && !sel_r[`APFS_RX_BIT]
        |=> pad_oe[APFS_RC5] == $past(gpio_oe[APFS_RC5])
            && pad_out[APFS_RC5] == $past(gpio_out[APFS_RC5]))
        else $error("unselected RC5 lost port behaviour");

    write_done_c: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
    rx_alt_c:     cover property (sel_r[`APFS_RX_BIT] && serial_receive_data_oe);
    gate_alt_c:   cover property (sel_r[`APFS_TG_BIT] ##1 timer_gate_input);
    bad_read_c:   cover property (s_axi_rvalid && s_axi_rresp == `APFS_RESP_DECERR);

endmodule

`default_nettype wire

//--- test/apfs_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "apfs_regs.svh"

module apfs_pad_model (
    input  wire logic [`APFS_NPIN-1:0] pad_out,
    input  wire logic [`APFS_NPIN-1:0] pad_oe,
    input  wire logic [`APFS_NPIN-1:0] ext_val,
    output logic      [`APFS_NPIN-1:0] pad_in
);
    // A pad that the block releases is held by the external device, so no pin floats.
    // Without that, an input check would hinge on how the simulator settles an unknown.
    always_comb
        pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule

`default_nettype wire

//--- test/tb_alt_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "apfs_regs.svh"

module tb_alt_pin_function_select;
    localparam int NP = `APFS_NPIN;
    logic          clk_sys;
    logic          rst;
    logic [3:0]    awaddr;
    logic          awvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          wvalid;
    logic          bready;
    logic [3:0]    araddr;
    logic          arvalid;
    logic          rready;
    logic [NP-1:0] gpio_out;
    logic [NP-1:0] gpio_oe;
    logic [NP-1:0] ext_val;
    logic [5:0]    fn_drv;
    logic [7:0]    sel_m [2];
    logic [31:0]   rng = 32'h0000_002E;
    int            error_cnt = 0;
    int            compares = 0;
    int            cyc = 0;
    wire           awready [2];
    wire           wready  [2];
    wire  [1:0]    bresp   [2];
    wire           bvalid  [2];
    wire           arready [2];
    wire  [31:0]   rdata   [2];
    wire  [1:0]    rresp   [2];
    wire           rvalid  [2];
    wire  [NP-1:0] pad_in  [2];
    wire  [NP-1:0] pad_out [2];
    wire  [NP-1:0] pad_oe  [2];
    wire  [NP-1:0] gpio_in [2];
    wire           rx_in   [2];
    wire           tx_in   [2];
    wire           ssn     [2];
    wire           tg      [2];

    // Instance 0 is the 20-pin variant, instance 1 the 14-pin one; both see the same stimulus.
    for (genvar i = 0; i < 2; i++)
    begin : g
        apfs_top #(.PIN20(i == 0), .ADDR_W(4)) dut (
            .clk_sys(clk_sys), .rst(rst),
            .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready[i]),
            .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
            .s_axi_wready(wready[i]), .s_axi_bresp(bresp[i]), .s_axi_bvalid(bvalid[i]),
            .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
            .s_axi_arready(arready[i]), .s_axi_rdata(rdata[i]), .s_axi_rresp(rresp[i]),
            .s_axi_rvalid(rvalid[i]), .s_axi_rready(rready),
            .pad_in(pad_in[i]), .pad_out(pad_out[i]), .pad_oe(pad_oe[i]),
            .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in[i]),
            .serial_receive_data_out(fn_drv[0]), .serial_receive_data_oe(fn_drv[1]),
            .serial_receive_data_in(rx_in[i]),
            .serial_transmit_clock_out(fn_drv[2]), .serial_transmit_clock_oe(fn_drv[3]),
            .serial_transmit_clock_in(tx_in[i]),
            .spi_serial_dout(fn_drv[4]), .spi_serial_dout_oe(fn_drv[5]),
            .spi_slave_select_in_n(ssn[i]), .timer_gate_input(tg[i]));
        apfs_pad_model pm (.pad_out(pad_out[i]), .pad_oe(pad_oe[i]), .ext_val(ext_val),
                           .pad_in(pad_in[i]));
    end

    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Pin code per function: 0 rx, 1 spi out, 2 slave select, 3 timer gate, 4 tx.
    function automatic int route(input bit v20, input logic [7:0] s, input int f);
        case (f)
            0: return v20 ? (s[7] ? 9 : 4) : (s[7] ? 1 : 9);
            1: return v20 ? 11 : (s[6] ? 3 : 6);
            2: return v20 ? 10 : (s[5] ? 2 : 7);
            3: return s[3] ? 2 : 3;
            default: return v20 ? (s[2] ? 8 : 5) : (s[2] ? 0 : 8);
        endcase
    endfunction

    function automatic logic [31:0] stat(input bit v20, input logic [7:0] s);
        logic [31:0] w;
        w = {11'h000, v20, 20'h00000};
        for (int f = 0; f < 5; f++)
            w[4*f +: 4] = 4'(route(v20, s, f));
        return w;
    endfunction

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [3:0] r);
        bit aw_t;
        bit w_t;
        bit b_t;
        @(posedge clk_sys);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        b_t = 1'b0;
        while (!b_t)
        begin
            @(negedge clk_sys);
            aw_t = awvalid && awready[0];
            w_t  = wvalid && wready[0];
            b_t  = bvalid[0];
            r    = {bresp[0], bresp[1]};
            @(posedge clk_sys);
            if (aw_t)
                awvalid <= 1'b0;
            if (w_t)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d0,
                          output logic [31:0] d1, output logic [3:0] r);
        bit ar_t;
        bit r_t;
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        r_t = 1'b0;
        while (!r_t)
        begin
            @(negedge clk_sys);
            ar_t = arvalid && arready[0];
            r_t  = rvalid[0];
            d0   = rdata[0];
            d1   = rdata[1];
            r    = {rresp[0], rresp[1]};
            @(posedge clk_sys);
            if (ar_t)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [3:0] r;
        logic [1:0] er;
        er = (a[3:2] < 2) ? 2'b00 : 2'b11;
        axi_wr(a, d, s, r);
        chk(r, {er, er});
        if (a[3:2] == 0 && s[0])
        begin
            sel_m[0] = d[7:0] & 8'h8C;
            sel_m[1] = d[7:0] & 8'hEC;
        end
    endtask

    task automatic check_regs();
        logic [31:0] d0;
        logic [31:0] d1;
        logic [3:0]  r;
        axi_rd(4'h0, d0, d1, r);
        chk(d0, {24'h000000, sel_m[0]});
        chk(d1, {24'h000000, sel_m[1]});
        chk(r, 4'h0);
        axi_rd(4'h4, d0, d1, r);
        chk(d0, stat(1'b1, sel_m[0]));
        chk(d1, stat(1'b0, sel_m[1]));
    endtask

    task automatic check_pins();
        logic [NP-1:0] eo;
        logic [NP-1:0] ev;
        logic [NP-1:0] lv;
        int            p;
        for (int i = 0; i < 2; i++)
        begin
            eo = gpio_oe;
            ev = gpio_out;
            for (int k = 0; k < 3; k++)
            begin
                p = route(i == 0, sel_m[i], k == 0 ? 0 : (k == 1 ? 4 : 1));
                if (fn_drv[2*k+1])
                begin
                    eo[p] = 1'b1;
                    ev[p] = fn_drv[2*k];
                end
            end
            lv = (eo & ev) | (~eo & ext_val);
            chk(pad_oe[i], eo);
            chk(pad_out[i], ev);
            chk(gpio_in[i], lv);
            chk(rx_in[i], lv[route(i == 0, sel_m[i], 0)]);
            chk(ssn[i], lv[route(i == 0, sel_m[i], 2)]);
            chk(tg[i], lv[route(i == 0, sel_m[i], 3)]);
            chk(tx_in[i], lv[route(i == 0, sel_m[i], 4)]);
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever
            #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    initial
    begin
        logic [31:0] x;
        logic [31:0] d0;
        logic [31:0] d1;
        logic [3:0]  r;
        rst = 1'b1;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, gpio_out, gpio_oe, ext_val, fn_drv} = '0;
        sel_m[0] = 8'h00;
        sel_m[1] = 8'h00;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        check_regs();
        check_pins();
        wr_chk(4'h8, 32'hFFFF_FFFF, 4'hF);
        axi_rd(4'hC, d0, d1, r);
        chk(d0 | d1, 32'h0000_0000);
        chk(r, 4'hF);
        wr_chk(4'h4, 32'hFFFF_FFFF, 4'hF);
        wr_chk(4'h0, 32'h0000_00FF, 4'hE);
        check_regs();
        // Random select values reach every mode of each bit in both variants.
        for (int n = 0; n < 48; n++)
        begin
            x = xorshift();
            wr_chk(4'h0, x, {x[10:8], x[11] | x[12]});
            x = xorshift();
            gpio_out <= x[11:0];
            gpio_oe  <= x[23:12];
            fn_drv   <= x[29:24];
            x = xorshift();
            ext_val  <= x[11:0];
            check_regs();
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            check_pins();
        end
        give_verdict();
    end
endmodule

`default_nettype wire
